// file: hdl/irq_bank_pkg.sv
// Constants, layouts and carrier types of the interrupt flag and enable bank
package irq_bank_pkg;

  localparam int REG_W = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int EVT_W = 4;

  // Register byte offsets on the bus
  localparam logic [ADDR_W-1:0] OFF_FLAG_STATUS_THREE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FLAG_STATUS_FOUR = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FLAG_STATUS_FIVE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ENABLE_CONTROL_ZERO = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_EVT_CLEAR = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_EVT_ENABLE = 8'h18;

  // Field positions, third flag register
  localparam int POS_CLOCK_CALENDAR_FLAG = 14;
  localparam int POS_EXT_IRQ4_FLAG = 6;
  localparam int POS_EXT_IRQ3_FLAG = 5;
  localparam int POS_I2C2_MASTER_FLAG = 2;
  localparam int POS_I2C2_SLAVE_FLAG = 1;
  // Fourth flag register
  localparam int POS_CHARGE_TIME_UNIT_FLAG = 13;
  localparam int POS_LOW_VOLTAGE_FLAG = 8;
  localparam int POS_CRC_GEN_FLAG = 3;
  localparam int POS_UART2_ERROR_FLAG = 2;
  localparam int POS_UART1_ERROR_FLAG = 1;
  // Fifth flag register
  localparam int POS_CAPTURE9_FLAG = 13;
  localparam int POS_COMPARE9_FLAG = 12;
  localparam int POS_SPI3_EVENT_FLAG = 11;
  localparam int POS_SPI3_FAULT_FLAG = 10;
  localparam int POS_UART4_TRANSMIT_FLAG = 9;
  localparam int POS_UART4_RECEIVE_FLAG = 8;
  localparam int POS_UART4_ERROR_FLAG = 7;
  localparam int POS_I2C3_MASTER_FLAG = 5;
  localparam int POS_I2C3_SLAVE_FLAG = 4;
  localparam int POS_UART3_TRANSMIT_FLAG = 3;
  localparam int POS_UART3_RECEIVE_FLAG = 2;
  localparam int POS_UART3_ERROR_FLAG = 1;
  // Enable register zero
  localparam int POS_ADC_DONE_ENABLE = 13;
  localparam int POS_UART1_TRANSMIT_ENABLE = 12;
  localparam int POS_UART1_RECEIVE_ENABLE = 11;
  localparam int POS_SPI1_DONE_ENABLE = 10;
  localparam int POS_SPI1_FAULT_ENABLE = 9;
  localparam int POS_TIMER3_IRQ_ENABLE = 8;
  localparam int POS_TIMER2_IRQ_ENABLE = 7;
  localparam int POS_COMPARE2_ENABLE = 6;
  localparam int POS_CAPTURE2_ENABLE = 5;
  localparam int POS_TIMER1_IRQ_ENABLE = 3;
  localparam int POS_COMPARE1_ENABLE = 2;
  localparam int POS_CAPTURE1_ENABLE = 1;
  localparam int POS_EXT_IRQ0_ENABLE = 0;

  // Implemented-bit masks
  localparam logic [REG_W-1:0] MASK_FLAG_STATUS_THREE = 16'h4066;
  localparam logic [REG_W-1:0] MASK_FLAG_STATUS_FOUR = 16'h210E;
  // Fifth: 13..7 and 5..1
  localparam logic [REG_W-1:0] MASK_FLAG_STATUS_FIVE = 16'h3FBE;
  // Enable zero: 13..5 and 3..0
  localparam logic [REG_W-1:0] MASK_ENABLE_CONTROL_ZERO = 16'h3FEF;

  // Values after reset
  localparam logic [REG_W-1:0] RST_REG = 16'h0000;
  localparam logic [EVT_W-1:0] RST_EVT = 4'h0;
  localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;

  // Event status bits
  localparam int EVT_NEW_THREE = 0;
  localparam int EVT_NEW_FOUR = 1;
  localparam int EVT_NEW_FIVE = 2;
  localparam int EVT_BUS_ERROR = 3;

  typedef enum logic {BUS_WAIT, BUS_ANSWER} bus_state_t;

  typedef struct packed {
    logic [REG_W-1:0] five;
    logic [REG_W-1:0] four;
    logic [REG_W-1:0] three;
  } flag_set_t;

  typedef struct packed {
    logic [REG_W-1:0] enable_zero;
    logic [REG_W-1:0] five;
    logic [REG_W-1:0] four;
    logic [REG_W-1:0] three;
  } flag_view_t;

endpackage

// file: hdl/flag_cell_bank.sv
// One 16-bit bank of sticky, software-writable flag cells
`timescale 1ns/100ps
`default_nettype none
module flag_cell_bank
  import irq_bank_pkg::*;
#(
  parameter logic [REG_W-1:0] IMPL_MASK = 16'h0000
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [REG_W-1:0] i_set,
  input wire logic i_wr,
  input wire logic [REG_W-1:0] i_wlane,
  input wire logic [REG_W-1:0] i_wdata,
  output logic [REG_W-1:0] o_q
);

  genvar i;
  generate
    for (i = 0; i < REG_W; i++) begin : g_cell
      if (IMPL_MASK[i]) begin : g_impl
        logic cell_q;
        always_ff @(posedge i_clk) begin
          if (i_rst) begin
            cell_q <= RST_REG[i];
          end else if (i_ce) begin
            if (i_set[i]) begin
              cell_q <= 1'b1;
            end else if (i_wr && i_wlane[i]) begin
              cell_q <= i_wdata[i];
            end
          end
        end
        assign o_q[i] = cell_q;
      end else begin : g_none
        assign o_q[i] = 1'b0;
      end
    end
  endgenerate

endmodule // flag_cell_bank
`default_nettype wire

// file: hdl/interrupt_flag_enable_bank.sv
// Interrupt flag and enable register bank with APB slave and event interrupt
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Third flag register: bits 14, 6, 5, 2, 1 implemented.
// - Fourth flag register: bits 13, 8, 3, 2, 1 implemented.
// - Fifth flag register: bits 13 to 7 and 5 to 1 implemented.
// - Enable register zero: bits 13 to 5 and 3 to 0 implemented.
// - Flag reads one after its source requested, zero otherwise.
// - Enable one passes the source request; zero blocks it.
// - Software reads and writes every implemented flag and enable bit.
// - Unimplemented bits read zero and ignore writes.
// - Reset clears every flag and enable bit.
module interrupt_flag_enable_bank
  import irq_bank_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_CLK_EN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [DATA_W-1:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic O_PREADY,
  output logic [DATA_W-1:0] O_PRDATA,
  output logic O_PSLVERR,
  input wire flag_set_t I_FLAG_SET,
  input wire logic [REG_W-1:0] I_FLAG_ZERO,
  output flag_view_t O_FLAGS,
  output logic [REG_W-1:0] O_REQ_ZERO,
  output logic O_IRQ
);

  bus_state_t state_q;
  bus_state_t state_d;
  logic pready_q;
  logic pslverr_q;
  logic [DATA_W-1:0] prdata_q;
  logic [EVT_W-1:0] evt_stat_q;
  logic [EVT_W-1:0] evt_stat_d;
  logic [EVT_W-1:0] evt_en_q;
  logic [EVT_W-1:0] evt_set;
  logic [REG_W-1:0] req_q;
  logic irq_q;
  logic [REG_W-1:0] three_q;
  logic [REG_W-1:0] four_q;
  logic [REG_W-1:0] five_q;
  logic [REG_W-1:0] en0_q;

  // Address decode
  wire access = I_PSEL && I_PENABLE;
  wire first_cyc = access && (state_q == BUS_WAIT);
  wire fire = access && pready_q && I_CLK_EN;
  wire wr_fire = fire && I_PWRITE;
  wire hit_three = (I_PADDR == OFF_FLAG_STATUS_THREE);
  wire hit_four = (I_PADDR == OFF_FLAG_STATUS_FOUR);
  wire hit_five = (I_PADDR == OFF_FLAG_STATUS_FIVE);
  wire hit_en0 = (I_PADDR == OFF_ENABLE_CONTROL_ZERO);
  wire hit_stat = (I_PADDR == OFF_EVT_STATUS);
  wire hit_clr = (I_PADDR == OFF_EVT_CLEAR);
  wire hit_een = (I_PADDR == OFF_EVT_ENABLE);
  wire mapped = hit_three || hit_four || hit_five || hit_en0 || hit_stat || hit_clr || hit_een;
  wire [REG_W-1:0] wlane = {{8{I_PSTRB[1]}}, {8{I_PSTRB[0]}}};
  wire [REG_W-1:0] wdata16 = I_PWDATA[REG_W-1:0];
  wire [EVT_W-1:0] wevt = I_PWDATA[EVT_W-1:0] & {EVT_W{I_PSTRB[0]}};

  // Read selection
  // flags read back
  logic [REG_W-1:0] rd_val;
  always_comb begin
    if (hit_three) begin
      rd_val = three_q;
    end else if (hit_four) begin
      rd_val = four_q;
    end else if (hit_five) begin
      rd_val = five_q;
    end else if (hit_en0) begin
      rd_val = en0_q;
    end else if (hit_stat) begin
      rd_val = {{(REG_W-EVT_W){1'b0}}, evt_stat_q};
    end else if (hit_een) begin
      rd_val = {{(REG_W-EVT_W){1'b0}}, evt_en_q};
    end else begin
      rd_val = RST_REG;
    end
  end

  // Bus handshake: one wait cycle, then answer
  always_comb begin
    case (state_q)
      BUS_WAIT: state_d = first_cyc ? BUS_ANSWER : BUS_WAIT;
      BUS_ANSWER: state_d = BUS_WAIT;
      default: state_d = BUS_WAIT;
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      state_q <= BUS_WAIT;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= RST_DATA;
    end else if (I_CLK_EN) begin
      state_q <= state_d;
      pready_q <= first_cyc;
      pslverr_q <= first_cyc && !mapped;
      prdata_q <= (first_cyc && !I_PWRITE) ? {{(DATA_W-REG_W){1'b0}}, rd_val} : RST_DATA;
    end
  end

  flag_cell_bank #(.IMPL_MASK(MASK_FLAG_STATUS_THREE)) u_three (
    .i_clk(I_CLK_SYS), .i_rst(I_RST), .i_ce(I_CLK_EN), .i_set(I_FLAG_SET.three),
    .i_wr(wr_fire && hit_three), .i_wlane(wlane), .i_wdata(wdata16), .o_q(three_q)
  );
  flag_cell_bank #(.IMPL_MASK(MASK_FLAG_STATUS_FOUR)) u_four (
    .i_clk(I_CLK_SYS), .i_rst(I_RST), .i_ce(I_CLK_EN), .i_set(I_FLAG_SET.four),
    .i_wr(wr_fire && hit_four), .i_wlane(wlane), .i_wdata(wdata16), .o_q(four_q)
  );
  flag_cell_bank #(.IMPL_MASK(MASK_FLAG_STATUS_FIVE)) u_five (
    .i_clk(I_CLK_SYS), .i_rst(I_RST), .i_ce(I_CLK_EN), .i_set(I_FLAG_SET.five),
    .i_wr(wr_fire && hit_five), .i_wlane(wlane), .i_wdata(wdata16), .o_q(five_q)
  );
  flag_cell_bank #(.IMPL_MASK(MASK_ENABLE_CONTROL_ZERO)) u_en0 (
    .i_clk(I_CLK_SYS), .i_rst(I_RST), .i_ce(I_CLK_EN), .i_set(RST_REG),
    .i_wr(wr_fire && hit_en0), .i_wlane(wlane), .i_wdata(wdata16), .o_q(en0_q)
  );

  // Events: a flag newly raised by hardware, or an unmapped access
  assign evt_set[EVT_NEW_THREE] = |(I_FLAG_SET.three & ~three_q & MASK_FLAG_STATUS_THREE);
  assign evt_set[EVT_NEW_FOUR] = |(I_FLAG_SET.four & ~four_q & MASK_FLAG_STATUS_FOUR);
  assign evt_set[EVT_NEW_FIVE] = |(I_FLAG_SET.five & ~five_q & MASK_FLAG_STATUS_FIVE);
  assign evt_set[EVT_BUS_ERROR] = fire && !mapped;
  assign evt_stat_d = (evt_stat_q & ~((wr_fire && hit_clr) ? wevt : RST_EVT)) | evt_set;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      evt_stat_q <= RST_EVT;
      evt_en_q <= RST_EVT;
      irq_q <= 1'b0;
    end else if (I_CLK_EN) begin
      evt_stat_q <= evt_stat_d;
      if (wr_fire && hit_een) begin
        evt_en_q <= wevt;
      end
      irq_q <= |(evt_stat_d & ((wr_fire && hit_een) ? wevt : evt_en_q));
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      req_q <= RST_REG;
    end else if (I_CLK_EN) begin
      req_q <= I_FLAG_ZERO & en0_q;
    end
  end

  assign O_PREADY = pready_q;
  assign O_PSLVERR = pslverr_q;
  assign O_PRDATA = prdata_q;
  assign O_FLAGS = '{enable_zero: en0_q, five: five_q, four: four_q, three: three_q};
  assign O_REQ_ZERO = req_q;
  assign O_IRQ = irq_q;

  // Assertions
  property p_three_layout;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (three_q & ~MASK_FLAG_STATUS_THREE) == RST_REG;
  endproperty
  a_three_layout: assert property (p_three_layout) else $error("third flag stray bit");

  property p_four_layout;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (four_q & ~MASK_FLAG_STATUS_FOUR) == RST_REG;
  endproperty
  a_four_layout: assert property (p_four_layout) else $error("fourth flag stray bit");

  property p_five_layout;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (five_q & ~MASK_FLAG_STATUS_FIVE) == RST_REG;
  endproperty
  a_five_layout: assert property (p_five_layout) else $error("fifth flag stray bit");

  property p_en0_write;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (wr_fire && hit_en0 && I_PSTRB[1:0] == 2'b11) |=>
        en0_q == ($past(wdata16) & MASK_ENABLE_CONTROL_ZERO);
  endproperty
  a_en0_write: assert property (p_en0_write) else $error("enable write lost");

  property p_flag_set;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (I_CLK_EN && I_FLAG_SET.three[POS_CLOCK_CALENDAR_FLAG]) |=>
        three_q[POS_CLOCK_CALENDAR_FLAG] ##1 (three_q[POS_CLOCK_CALENDAR_FLAG] || $past(fire));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set by event");

  property p_req_gate;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      I_CLK_EN |=> O_REQ_ZERO == ($past(I_FLAG_ZERO) & $past(en0_q));
  endproperty
  a_req_gate: assert property (p_req_gate) else $error("request not gated");

  property p_flag_write;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (wr_fire && hit_four && I_PSTRB[1:0] == 2'b11 && I_FLAG_SET.four == RST_REG) |=>
        four_q == ($past(wdata16) & MASK_FLAG_STATUS_FOUR);
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("flag write lost");

  property p_unmapped_zero;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (O_PREADY && !I_PWRITE) |-> O_PRDATA[DATA_W-1:REG_W] == 16'h0000
        && (!O_PSLVERR || O_PRDATA == RST_DATA);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("upper read bits set");

  property p_reset_clear;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      $fell(I_RST) |-> (three_q == RST_REG && four_q == RST_REG && five_q == RST_REG
        && en0_q == RST_REG && !O_IRQ);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not cleared");

  property p_sticky;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      !(wr_fire && hit_five) |=> (five_q & $past(five_q)) == $past(five_q);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without write");

  property p_ready_timing;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (first_cyc && I_CLK_EN) |=> O_PREADY ##1 !O_PREADY;
  endproperty
  a_ready_timing: assert property (p_ready_timing) else $error("ready timing wrong");

  property p_three_write;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (wr_fire && hit_three && I_PSTRB[1:0] == 2'b11 && I_FLAG_SET.three == RST_REG) |=>
        three_q == ($past(wdata16) & MASK_FLAG_STATUS_THREE);
  endproperty
  a_three_write: assert property (p_three_write) else $error("third flag write lost");

  property p_five_write;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (wr_fire && hit_five && I_PSTRB[1:0] == 2'b11 && I_FLAG_SET.five == RST_REG) |=>
        five_q == ($past(wdata16) & MASK_FLAG_STATUS_FIVE);
  endproperty
  a_five_write: assert property (p_five_write) else $error("fifth flag write lost");

  property p_en0_hold;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      !(wr_fire && hit_en0) |=> en0_q == $past(en0_q);
  endproperty
  a_en0_hold: assert property (p_en0_hold) else $error("enable changed without write");

  property p_set_wins;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (I_CLK_EN && I_FLAG_SET.five[POS_CAPTURE9_FLAG]) |=> five_q[POS_CAPTURE9_FLAG];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost against write");

  property p_irq_level;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      O_IRQ == |(evt_stat_q & evt_en_q);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_lane_keep;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (wr_fire && hit_three && I_PSTRB[1:0] == 2'b01 && I_FLAG_SET.three == RST_REG) |=>
        three_q[15:8] == $past(three_q[15:8]);
  endproperty
  a_lane_keep: assert property (p_lane_keep) else $error("masked lane written");

  property p_four_sticky;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      !(wr_fire && hit_four) |=> (four_q & $past(four_q)) == $past(four_q);
  endproperty
  a_four_sticky: assert property (p_four_sticky) else $error("flag dropped without write");

  property p_err_event;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (fire && !mapped) |=> evt_stat_q[EVT_BUS_ERROR];
  endproperty
  a_err_event: assert property (p_err_event) else $error("bus error event lost");

  c_flag_set: cover property (@(posedge I_CLK_SYS) disable iff (I_RST) $rose(five_q[13]));
  c_sw_clear: cover property (@(posedge I_CLK_SYS) disable iff (I_RST) $fell(three_q[14]));
  c_irq: cover property (@(posedge I_CLK_SYS) disable iff (I_RST) $rose(O_IRQ));
  c_bus_err: cover property (@(posedge I_CLK_SYS) disable iff (I_RST) O_PREADY && O_PSLVERR);
  c_lane_write: cover property (@(posedge I_CLK_SYS) disable iff (I_RST)
    wr_fire && I_PSTRB[1:0] == 2'b01);

endmodule // interrupt_flag_enable_bank
`default_nettype wire

// file: verif/event_source_model.sv
// Model of the peripheral event sources feeding the flag bank
`timescale 1ns/100ps
`default_nettype none
module event_source_model
  import irq_bank_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_fire,
  input wire flag_set_t i_pattern,
  input wire logic [REG_W-1:0] i_level,
  output flag_set_t o_set,
  output logic [REG_W-1:0] o_zero
);
  // Set pulses last one cycle, then the lines go idle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_set <= '0;
      o_zero <= RST_REG;
    end else begin
      o_set <= i_fire ? i_pattern : '0;
      o_zero <= i_level;
    end
  end
endmodule // event_source_model
`default_nettype wire

// file: verif/tb_interrupt_flag_enable_bank.sv
// Self-checking bench for the interrupt flag and enable bank
`timescale 1ns/100ps
`default_nettype none
module tb_interrupt_flag_enable_bank
  import irq_bank_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, fire = 1'b0, ce = 1'b1;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, rd, d, prd;
  logic [3:0] pstrb = 4'h3;
  flag_set_t pat = '0, set_w;
  logic [REG_W-1:0] lvl = '0, zero_w, req;
  logic rdy, err, irq, e;
  flag_view_t flags;
  logic [REG_W-1:0] exp_q [4];
  int error_cnt = 0, total_checks = 0, r;

  initial forever #4 clk = ~clk;

  interrupt_flag_enable_bank interrupt_flag_enable_bank_i (.I_CLK_SYS(clk), .I_RST(rst),
    .I_CLK_EN(ce), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PREADY(rdy), .O_PRDATA(prd), .O_PSLVERR(err),
    .I_FLAG_SET(set_w), .I_FLAG_ZERO(zero_w), .O_FLAGS(flags), .O_REQ_ZERO(req),
    .O_IRQ(irq));
  event_source_model event_source_model_i (.i_clk(clk), .i_rst(rst), .i_fire(fire),
    .i_pattern(pat), .i_level(lvl), .o_set(set_w), .o_zero(zero_w));

  task automatic chk(input logic [63:0] seen, input logic [63:0] expv);
    total_checks++;
    if (seen !== expv) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    int n;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (rdy === 1'b1) break;
    end
    if (n == 20) begin
      error_cnt++;
      final_report();
    end
    rd = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  // Implemented bits of each register
  function automatic logic [REG_W-1:0] impl(input int i);
    case (i)
      0: return 16'h4066;
      1: return 16'h210E;
      2: return 16'h3FBE;
      default: return 16'h3FEF;
    endcase
  endfunction

  initial begin
    void'($urandom(14));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (r = 0; r < 4; r++) begin
      apb(1'b0, ADDR_W'(r * 4), '0);
      chk(rd, '0);
      exp_q[r] = '0;
      apb(1'b1, ADDR_W'(r * 4), 32'hFFFF_FFFF);
      apb(1'b0, ADDR_W'(r * 4), '0);
      chk(rd, {16'h0000, impl(r)});
      apb(1'b1, ADDR_W'(r * 4), '0);
      apb(1'b0, ADDR_W'(r * 4), '0);
      chk(rd, '0);
    end
    for (int k = 0; k < 80; k++) begin
      r = $urandom_range(3);
      lvl <= 16'($urandom());
      if ($urandom_range(1) == 1) begin
        d = $urandom();
        apb(1'b1, ADDR_W'(r * 4), d);
        exp_q[r] = d[15:0] & impl(r);
      end else begin
        pat <= {16'($urandom()), 16'($urandom()), 16'($urandom())};
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (2) @(posedge clk);
        exp_q[0] = exp_q[0] | (pat.three & impl(0));
        exp_q[1] = exp_q[1] | (pat.four & impl(1));
        exp_q[2] = exp_q[2] | (pat.five & impl(2));
      end
      apb(1'b0, ADDR_W'(r * 4), '0);
      chk(rd, {16'h0000, exp_q[r]});
      chk(flags, {exp_q[3], exp_q[2], exp_q[1], exp_q[0]});
      chk(req, lvl & exp_q[3]);
    end
    // Clock enable low: a set pulse must leave the bank frozen
    ce <= 1'b0;
    pat <= {3{16'hFFFF}};
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (2) @(posedge clk);
    chk(flags, {exp_q[3], exp_q[2], exp_q[1], exp_q[0]});
    ce <= 1'b1;
    @(posedge clk);
    // Low byte lane only
    pstrb <= 4'h1;
    apb(1'b1, OFF_FLAG_STATUS_THREE, 32'h0000_FFFF);
    pstrb <= 4'h3;
    exp_q[0] = (exp_q[0] & 16'hFF00) | (16'h00FF & impl(0));
    apb(1'b0, OFF_FLAG_STATUS_THREE, '0);
    chk(rd, {16'h0000, exp_q[0]});
    // Reset in mid-run clears everything
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (r = 0; r < 4; r++) exp_q[r] = '0;
    chk(flags, {exp_q[3], exp_q[2], exp_q[1], exp_q[0]});
    apb(1'b1, OFF_EVT_CLEAR, 32'h0000_000F);
    apb(1'b1, OFF_EVT_ENABLE, 32'h0000_0008);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b0, 8'h40, '0);
    chk({e, rd}, {1'b1, 32'h0000_0000});
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    apb(1'b0, OFF_EVT_STATUS, '0);
    chk(rd & 32'h0000_0008, 32'h0000_0008);
    apb(1'b1, OFF_EVT_ENABLE, '0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b1, OFF_EVT_CLEAR, 32'h0000_0008);
    apb(1'b0, OFF_EVT_STATUS, '0);
    chk(rd & 32'h0000_0008, '0);
    final_report();
  end
endmodule // tb_interrupt_flag_enable_bank
`default_nettype wire
